// ### src/vrc_axil_slave.sv
// vrc_axil_slave.sv: AXI4-Lite slave that turns bus writes into one-cycle
// register strobes and answers reads from a combinational read port.
// assumes: one clock, synchronous active-high reset, one write and one read
// under way at a time.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_map.svh"

module vrc_axil_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [31:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output vrc_pkg::vrc_wr_s wr_o,
  input wire logic wr_err_i,
  output logic [31:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);

  // ========================================================================
  // write channel
  vrc_pkg::vrc_wst_e wst_r, wst_nxt;
  logic [31:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;

  // address and data are caught in either order; the strobe fires one
  // cycle after the later of the two so the decode sees stable values
  always_comb begin
    wst_nxt = wst_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    wr_o = '0;
    unique case (wst_r)
      vrc_pkg::VRC_WS_IDLE: begin
        if (awvalid_i && awready_r) begin
          awaddr_nxt = awaddr_i;
          aw_got_nxt = 1'b1;
        end
        if (wvalid_i && wready_r) begin
          wdata_nxt = wdata_i;
          wstrb_nxt = wstrb_i;
          w_got_nxt = 1'b1;
        end
        if (aw_got_r && w_got_r) begin
          wr_o.en = 1'b1;
          wr_o.addr = awaddr_r;
          wr_o.data = wdata_r;
          wr_o.strb = wstrb_r;
          bvalid_nxt = 1'b1;
          bresp_nxt = wr_err_i ? `VRC_RESP_SLVERR : `VRC_RESP_OKAY;
          aw_got_nxt = 1'b0;
          w_got_nxt = 1'b0;
          wst_nxt = vrc_pkg::VRC_WS_RESP;
          awready_nxt = 1'b0;
          wready_nxt = 1'b0;
        end else begin
          awready_nxt = ~aw_got_nxt;
          wready_nxt = ~w_got_nxt;
        end
      end
      vrc_pkg::VRC_WS_RESP: begin
        if (bready_i) begin
          bvalid_nxt = 1'b0;
          awready_nxt = 1'b1;
          wready_nxt = 1'b1;
          wst_nxt = vrc_pkg::VRC_WS_IDLE;
        end
      end
      default: begin
        wst_nxt = vrc_pkg::VRC_WS_IDLE;
        bvalid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wst_r <= vrc_pkg::VRC_WS_IDLE;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `VRC_RESP_OKAY;
    end else begin
      wst_r <= wst_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // ========================================================================
  // read channel
  vrc_pkg::vrc_rst_e rst_st_r, rst_st_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // data is sampled at the address handshake, so raw status reads show
  // the merged requests of that very edge
  always_comb begin
    rst_st_nxt = rst_st_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    unique case (rst_st_r)
      vrc_pkg::VRC_RS_IDLE: begin
        arready_nxt = 1'b1;
        if (arvalid_i && arready_r) begin
          rdata_nxt = rd_data_i;
          rresp_nxt = rd_err_i ? `VRC_RESP_SLVERR : `VRC_RESP_OKAY;
          rvalid_nxt = 1'b1;
          arready_nxt = 1'b0;
          rst_st_nxt = vrc_pkg::VRC_RS_DATA;
        end
      end
      vrc_pkg::VRC_RS_DATA: begin
        if (rready_i) begin
          rvalid_nxt = 1'b0;
          arready_nxt = 1'b1;
          rst_st_nxt = vrc_pkg::VRC_RS_IDLE;
        end
      end
      default: begin
        rst_st_nxt = vrc_pkg::VRC_RS_IDLE;
        rvalid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_st_r <= vrc_pkg::VRC_RS_IDLE;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `VRC_RESP_OKAY;
    end else begin
      rst_st_r <= rst_st_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign rd_addr_o = araddr_i;
  assign awready_o = awready_r;
  assign wready_o = wready_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign arready_o = arready_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;

endmodule

`default_nettype wire

// ### src/vrc_front_end.sv
// vrc_front_end.sv: request front end of the vectored request controller:
// request merge, software forcing, raw status, enable mask, fast/normal
// routing and an event interrupt, all behind an AXI4-Lite slave.
// assumes: request lines synchronous to SYS_CLK_I; one AXI4-Lite master.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_map.svh"

module vrc_front_end (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [31:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [31:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic [31:0] PERIPH_REQ_I,
  output logic FAST_INT_O,
  output logic NORMAL_INT_O,
  output logic EVT_IRQ_O
);

  // ========================================================================
  // bus slave
  vrc_pkg::vrc_wr_s wr_req;
  logic wr_err;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  vrc_axil_slave u_slave (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .awaddr_i(AWADDR_I),
    .awvalid_i(AWVALID_I),
    .awready_o(AWREADY_O),
    .wdata_i(WDATA_I),
    .wstrb_i(WSTRB_I),
    .wvalid_i(WVALID_I),
    .wready_o(WREADY_O),
    .bresp_o(BRESP_O),
    .bvalid_o(BVALID_O),
    .bready_i(BREADY_I),
    .araddr_i(ARADDR_I),
    .arvalid_i(ARVALID_I),
    .arready_o(ARREADY_O),
    .rdata_o(RDATA_O),
    .rresp_o(RRESP_O),
    .rvalid_o(RVALID_O),
    .rready_i(RREADY_I),
    .wr_o(wr_req),
    .wr_err_i(wr_err),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  // ========================================================================
  // byte lanes
  // unstrobed lanes write zeros, which the set/clear registers ignore
  logic [31:0] wmask;
  logic [31:0] wbits;

  for (genvar gi = 0; gi < 4; gi++) begin : g_lane
    assign wmask[gi*8 +: 8] = {8{wr_req.strb[gi]}};
  end

  assign wbits = wr_req.data & wmask;

  // ========================================================================
  // state
  logic [31:0] soft_r, soft_nxt;
  logic [31:0] enable_r, enable_nxt;
  logic [31:0] select_r, select_nxt;
  logic [`VRC_EVT_W-1:0] evt_stat_r, evt_stat_nxt;
  logic [`VRC_EVT_W-1:0] evt_mask_r, evt_mask_nxt;
  logic [`VRC_EVT_W-1:0] evt_clr;
  logic [`VRC_EVT_W-1:0] evt_set;
  logic fast_r, fast_nxt;
  logic normal_r, normal_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] raw;
  logic [31:0] routed;

  // request lines outside the source map are dropped at the merge, so a
  // stray level on an unused input cannot show up in raw status
  assign raw = (PERIPH_REQ_I & `VRC_SRC_MAP) | soft_r;

  // unused positions may still be forced and enabled in software, but
  // they are cut here before routing
  assign routed = raw & enable_r & `VRC_SRC_MAP;

  // ========================================================================
  // register writes and output routing
  always_comb begin
    soft_nxt = soft_r;
    enable_nxt = enable_r;
    select_nxt = select_r;
    evt_mask_nxt = evt_mask_r;
    evt_clr = '0;
    if (wr_req.en) begin
      case (wr_req.addr)
        `VRC_OFS_SOFT: begin
          soft_nxt = soft_r | wbits;
        end
        `VRC_OFS_SOFT_CLR: begin
          soft_nxt = soft_r & ~wbits;
        end
        `VRC_OFS_ENABLE: begin
          enable_nxt = enable_r | wbits;
        end
        `VRC_OFS_FAST_SEL: begin
          select_nxt = (select_r & ~wmask) | wbits;
        end
        `VRC_OFS_EVT_STAT: begin
          evt_clr = wbits[`VRC_EVT_W-1:0];
        end
        `VRC_OFS_EVT_MASK: begin
          evt_mask_nxt = (evt_mask_r & ~wmask[`VRC_EVT_W-1:0]) | wbits[`VRC_EVT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    fast_nxt = |(routed & select_r);
    normal_nxt = |(routed & ~select_r);
    evt_set = '0;
    evt_set[`VRC_EVT_FAST] = fast_nxt & ~fast_r;
    evt_set[`VRC_EVT_NORMAL] = normal_nxt & ~normal_r;
    // a new event in the clearing cycle survives the clear
    evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;
    irq_nxt = |(evt_stat_nxt & evt_mask_nxt);
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      soft_r <= `VRC_RST_WORD;
      enable_r <= `VRC_RST_WORD;
      select_r <= `VRC_RST_WORD;
      evt_stat_r <= `VRC_RST_EVT;
      evt_mask_r <= `VRC_RST_EVT;
      fast_r <= 1'b0;
      normal_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      soft_r <= soft_nxt;
      enable_r <= enable_nxt;
      select_r <= select_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
      fast_r <= fast_nxt;
      normal_r <= normal_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ========================================================================
  // address decode
  always_comb begin
    wr_err = 1'b0;
    case (wr_req.addr)
      `VRC_OFS_SOFT, `VRC_OFS_SOFT_CLR, `VRC_OFS_ENABLE, `VRC_OFS_FAST_SEL,
      `VRC_OFS_RAW, `VRC_OFS_EVT_STAT, `VRC_OFS_EVT_MASK: begin
        wr_err = 1'b0;
      end
      default: begin
        wr_err = 1'b1;
      end
    endcase
  end

  // writes to raw status are accepted and ignored; force-clear reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (rd_addr)
      `VRC_OFS_RAW: begin
        rd_data = raw;
      end
      `VRC_OFS_ENABLE: begin
        rd_data = enable_r;
      end
      `VRC_OFS_SOFT: begin
        rd_data = soft_r;
      end
      `VRC_OFS_SOFT_CLR: begin
        rd_data = 32'h0000_0000;
      end
      `VRC_OFS_FAST_SEL: begin
        rd_data = select_r;
      end
      `VRC_OFS_EVT_STAT: begin
        rd_data[`VRC_EVT_W-1:0] = evt_stat_r;
      end
      `VRC_OFS_EVT_MASK: begin
        rd_data[`VRC_EVT_W-1:0] = evt_mask_r;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // ========================================================================
  // outputs
  assign FAST_INT_O = fast_r;
  assign NORMAL_INT_O = normal_r;
  assign EVT_IRQ_O = irq_r;

endmodule

`default_nettype wire

// ### src/vrc_map.svh
// vrc_map.svh: addresses, reset values, field positions and the source map
// of the vectored request controller front end.
// assumes: included by bare name after the package; definitions only.
`ifndef VRC_MAP_SVH
`define VRC_MAP_SVH

// ==========================================================================
// register byte addresses
`define VRC_OFS_FAST_SEL 32'hFFFF_F00C
`define VRC_OFS_RAW 32'hFFFF_F008
`define VRC_OFS_ENABLE 32'hFFFF_F010
`define VRC_OFS_SOFT 32'hFFFF_F018
`define VRC_OFS_SOFT_CLR 32'hFFFF_F01C
`define VRC_OFS_EVT_STAT 32'hFFFF_F030
`define VRC_OFS_EVT_MASK 32'hFFFF_F034

// ==========================================================================
// reset values
`define VRC_RST_WORD 32'h0000_0000
`define VRC_RST_EVT 2'h0

// ==========================================================================
// source map: watchdog 0, core channels 2-3, counters a/b 4-5,
// async serial 6-7, two-wire a 9, sync serial 10-11, clock-lock 12,
// calendar 13, external pins 14-16, analog converter 18, two-wire b 19,
// counters c/d 26-27
`define VRC_SRC_MAP 32'h0C0D_FEFD

// ==========================================================================
// event status fields
`define VRC_EVT_FAST 0
`define VRC_EVT_NORMAL 1
`define VRC_EVT_W 2

// ==========================================================================
// bus responses
`define VRC_RESP_OKAY 2'h0
`define VRC_RESP_SLVERR 2'h2

`endif

// ### src/vrc_pkg.sv
// vrc_pkg.sv: types shared by the bus slave and the front end.
// assumes: compiled before every module of the block.
package vrc_pkg;

  // one register write, valid for the single cycle in which en is high
  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } vrc_wr_s;

  typedef enum logic [1:0] {
    VRC_WS_IDLE = 2'h0,
    VRC_WS_RESP = 2'h1
  } vrc_wst_e;

  typedef enum logic [1:0] {
    VRC_RS_IDLE = 2'h0,
    VRC_RS_DATA = 2'h1
  } vrc_rst_e;

endpackage

// ### tb/tb_top.sv
// tb_top.sv: self-checking bench for the request front end.
// assumes: vrc_periph_model drives the request lines, bench is bus master.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_map.svh"

module tb_top;
  // ==========================================================
  // signals and instances
  localparam logic [31:0] MAP_EXP = 32'h0C0D_FEFD;
  logic SYS_CLK_I = 1'h0;
  logic SYS_RST_I = 1'h1;
  logic [31:0] AWADDR_I = 32'h0, WDATA_I = 32'h0, ARADDR_I = 32'h0, req_cmd = 32'h0;
  logic [3:0] WSTRB_I = 4'hF;
  logic AWVALID_I = 1'h0, WVALID_I = 1'h0, BREADY_I = 1'h0, ARVALID_I = 1'h0;
  logic RREADY_I = 1'h0;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic FAST_INT_O, NORMAL_INT_O, EVT_IRQ_O;
  logic [1:0] BRESP_O, RRESP_O, rsp;
  logic [31:0] RDATA_O, PERIPH_REQ_I, frc_m, en_m, sel_m, rd, v;
  int miscompares = 0;
  int samples_checked = 0;
  // edges for which the master keeps bready/rready low, so the hold checks see a stall
  int hold = 0;

  vrc_front_end DUT (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
    .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
    .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
    .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .PERIPH_REQ_I(PERIPH_REQ_I), .FAST_INT_O(FAST_INT_O), .NORMAL_INT_O(NORMAL_INT_O),
    .EVT_IRQ_O(EVT_IRQ_O)
  );
  vrc_periph_model u_periph (.clk_i(SYS_CLK_I), .rst_i(SYS_RST_I), .lvl_i(req_cmd),
    .req_o(PERIPH_REQ_I));

  initial begin
    forever #25 SYS_CLK_I = ~SYS_CLK_I;
  end

  // ==========================================================
  // expectations and compares
  function automatic logic [31:0] raw_f(logic [31:0] p, logic [31:0] f);
    return (p & MAP_EXP) | f;
  endfunction
  function automatic logic [1:0] out_f(logic [31:0] p, f, e, s);
    logic [31:0] g;
    g = raw_f(p, f) & e & MAP_EXP;
    return {|(g & s), |(g & ~s)};
  endfunction
  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e, input string w);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic cmp_s(input logic [1:0] g, input logic [1:0] e, input string w);
    cmp_w({30'h0, g}, {30'h0, e}, w);
  endtask

  // ==========================================================
  // bus master; each access starts one edge after the last ended
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge SYS_CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'h1;
    WVALID_I <= 1'h1;
    BREADY_I <= (hold == 0);
    do begin
      @(posedge SYS_CLK_I);
      n++;
      if (AWREADY_O) AWVALID_I <= 1'h0;
      if (WREADY_O) WVALID_I <= 1'h0;
      if (n == hold) BREADY_I <= 1'h1;
    end while (!(BVALID_O === 1'h1 && BREADY_I === 1'h1) && n < 60);
    BREADY_I <= 1'h0;
    r = BRESP_O;
    if (n >= 60) cmp_w(32'h0, 32'h1, "write hang");
  endtask
  task automatic rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge SYS_CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'h1;
    RREADY_I <= (hold == 0);
    do begin
      @(posedge SYS_CLK_I);
      n++;
      if (ARREADY_O) ARVALID_I <= 1'h0;
      if (n == hold) RREADY_I <= 1'h1;
    end while (!(RVALID_O === 1'h1 && RREADY_I === 1'h1) && n < 60);
    RREADY_I <= 1'h0;
    d = RDATA_O;
    r = RRESP_O;
    if (n >= 60) cmp_w(32'h0, 32'h1, "read hang");
  endtask
  task automatic wr_ok(input logic [31:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    cmp_s(rsp, `VRC_RESP_OKAY, "bresp");
  endtask
  task automatic rd_cmp(input logic [31:0] a, input logic [31:0] e, input string w);
    rdr(a, rd, rsp);
    cmp_w(rd, e, w);
    cmp_s(rsp, `VRC_RESP_OKAY, "rresp");
  endtask

  // routing settles within three edges: request register and outputs take one each, raw is combinational
  task automatic chk_all;
    repeat (3) @(posedge SYS_CLK_I);
    cmp_s({FAST_INT_O, NORMAL_INT_O}, out_f(req_cmd, frc_m, en_m, sel_m), "out");
    rd_cmp(`VRC_OFS_RAW, raw_f(req_cmd, frc_m), "raw");
    rd_cmp(`VRC_OFS_SOFT, frc_m, "force");
    rd_cmp(`VRC_OFS_ENABLE, en_m, "enable");
    rd_cmp(`VRC_OFS_FAST_SEL, sel_m, "select");
  endtask
  task automatic do_reset;
    SYS_RST_I <= 1'h1;
    repeat (20) @(posedge SYS_CLK_I);
    SYS_RST_I <= 1'h0;
    frc_m = 32'h0;
    en_m = 32'h0;
    sel_m = 32'h0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    #1000000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    void'($urandom(42721));
    do_reset;
    chk_all;
    rd_cmp(`VRC_OFS_SOFT_CLR, 32'h0, "clear reads zero");
    wr(32'hFFFF_F014, 32'hFFFF_FFFF, rsp);
    cmp_s(rsp, `VRC_RESP_SLVERR, "bad write");
    rdr(32'hFFFF_F014, rd, rsp);
    cmp_s(rsp, `VRC_RESP_SLVERR, "bad read");
    $display("test reset and refusals done");
    // forced bits at unmapped places must not reach the outputs
    wr_ok(`VRC_OFS_ENABLE, 32'hFFFF_FFFF);
    en_m = 32'hFFFF_FFFF;
    wr_ok(`VRC_OFS_SOFT, ~MAP_EXP);
    frc_m = ~MAP_EXP;
    wr_ok(`VRC_OFS_RAW, 32'hFFFF_FFFF);
    chk_all;
    wr_ok(`VRC_OFS_SOFT_CLR, 32'hFFFF_FFFF);
    frc_m = 32'h0;
    chk_all;
    $display("test unmapped and bulk clear done");
    // event interrupt: raise, clear, mask
    wr_ok(`VRC_OFS_EVT_MASK, 32'h3);
    wr_ok(`VRC_OFS_SOFT, 32'h1);
    frc_m = 32'h1;
    chk_all;
    rd_cmp(`VRC_OFS_EVT_STAT, 32'h2, "event status");
    cmp_s({1'h0, EVT_IRQ_O}, 2'h1, "irq raised");
    wr_ok(`VRC_OFS_EVT_STAT, 32'h2);
    wr_ok(`VRC_OFS_EVT_MASK, 32'h0);
    wr_ok(`VRC_OFS_SOFT_CLR, 32'h1);
    wr_ok(`VRC_OFS_SOFT, 32'h1);
    chk_all;
    rd_cmp(`VRC_OFS_EVT_STAT, 32'h2, "masked status");
    cmp_s({1'h0, EVT_IRQ_O}, 2'h0, "irq masked");
    $display("test event interrupt done");
    // one byte lane only: the other lanes of the select register keep their bits
    hold = 3;
    WSTRB_I <= 4'h1;
    wr_ok(`VRC_OFS_FAST_SEL, 32'hFFFF_FFFF);
    WSTRB_I <= 4'hF;
    sel_m = 32'h0000_00FF;
    chk_all;
    hold = 0;
    $display("test strobes and stalls done");
    for (int i = 0; i < 80; i++) begin
      v = $urandom;
      if (i == 40) do_reset;
      case ($urandom_range(4))
        0: req_cmd <= v;
        1: begin wr_ok(`VRC_OFS_SOFT, v); frc_m = frc_m | v; end
        2: begin wr_ok(`VRC_OFS_SOFT_CLR, v); frc_m = frc_m & ~v; end
        3: begin v = v & $urandom & $urandom; wr_ok(`VRC_OFS_ENABLE, v); en_m = en_m | v; end
        default: begin wr_ok(`VRC_OFS_FAST_SEL, v); sel_m = v; end
      endcase
      chk_all;
    end
    $display("test random traffic done");
    report_and_stop;
  end
endmodule

`default_nettype wire

// ### tb/vrc_front_end_props.sv
// vrc_front_end_props.sv: port checker for the request front end.
// assumes: bound to every vrc_front_end instance, one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_map.svh"

module vrc_fe_props (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic [1:0] BRESP_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [31:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic [31:0] PERIPH_REQ_I,
  input wire logic FAST_INT_O,
  input wire logic NORMAL_INT_O,
  input wire logic EVT_IRQ_O
);
  // ==========================================================
  // bus steps
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic ar_bad;
  assign ar_bad = !(ARADDR_I inside {`VRC_OFS_RAW, `VRC_OFS_FAST_SEL, `VRC_OFS_ENABLE,
    `VRC_OFS_SOFT, `VRC_OFS_SOFT_CLR, `VRC_OFS_EVT_STAT, `VRC_OFS_EVT_MASK});
  sequence wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence rd_taken;
    ARVALID_I && ARREADY_O;
  endsequence

  // ==========================================================
  // assertions
  reset_quiet_a: assert property (disable iff (1'h0) SYS_RST_I |=>
    !FAST_INT_O && !NORMAL_INT_O && !EVT_IRQ_O) else $error("outputs not clear after reset");
  wr_answer_a: assert property (wr_taken |-> ##[2:3] BVALID_O)
    else $error("write response missing");
  bresp_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped");
  rd_answer_a: assert property (rd_taken |=> RVALID_O) else $error("read data late");
  rdata_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped");
  ready_block_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write taken during response");
  raw_merge_a: assert property (rd_taken ##0 ARADDR_I == `VRC_OFS_RAW
    && $stable(PERIPH_REQ_I) |=> (RDATA_O & $past(PERIPH_REQ_I) & `VRC_SRC_MAP)
    == ($past(PERIPH_REQ_I) & `VRC_SRC_MAP)) else $error("raw misses a request");
  clr_wo_a: assert property (rd_taken ##0 ARADDR_I == `VRC_OFS_SOFT_CLR |=>
    RDATA_O == 32'h0000_0000 && RRESP_O == `VRC_RESP_OKAY) else $error("clear reg readable");
  bad_read_a: assert property (rd_taken ##0 ar_bad |=> RRESP_O == `VRC_RESP_SLVERR
    && RDATA_O == 32'h0000_0000) else $error("unmapped read accepted");
endmodule

bind vrc_front_end vrc_fe_props u_props (
  .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
  .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
  .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
  .PERIPH_REQ_I(PERIPH_REQ_I), .FAST_INT_O(FAST_INT_O), .NORMAL_INT_O(NORMAL_INT_O),
  .EVT_IRQ_O(EVT_IRQ_O)
);

`default_nettype wire

// ### tb/vrc_periph_model.sv
// vrc_periph_model.sv: peripheral side of the request lines.
// assumes: bench sets the wanted levels; lines move only on clock edges.
`timescale 1ns/1ps
`default_nettype none

module vrc_periph_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] lvl_i,
  output logic [31:0] req_o
);
  // ==========================================================
  // request levels
  // registered so lines stay synchronous to the front end clock
  always_ff @(posedge clk_i) begin
    req_o <= rst_i ? 32'h0000_0000 : lvl_i;
  end
endmodule

`default_nettype wire
